// file: common/card_pwr_pkg.sv
package card_pwr_pkg;

  // sizes of the control word and of the output set
  localparam int WORD_BITS      = 11;
  localparam int RAIL_COUNT     = 4;
  localparam int SLOT_COUNT     = 2;
  localparam int RAILS_PER_SLOT = 2;
  localparam int SELECT_BITS    = 4;
  localparam int IRQ_BITS       = 4;
  localparam int OFFSET_BITS    = 8;

  // bit positions inside the serial control word
  localparam int BIT_A_AUX_SEL0 = 0;
  localparam int BIT_A_AUX_SEL1 = 1;
  localparam int BIT_A_VCC_LO   = 2;
  localparam int BIT_A_VCC_HI   = 3;
  localparam int BIT_B_AUX_SEL0 = 4;
  localparam int BIT_B_AUX_SEL1 = 5;
  localparam int BIT_B_VCC_HI   = 6;
  localparam int BIT_B_VCC_LO   = 7;
  localparam int SHUTDOWN_BIT   = 8;
  localparam int BIT_A_AUX_HV   = 9;
  localparam int BIT_B_AUX_HV   = 10;

  // rail order on the railCtrl port
  localparam int RAIL_A_VCC = 0;
  localparam int RAIL_A_AUX = 1;
  localparam int RAIL_B_VCC = 2;
  localparam int RAIL_B_AUX = 3;

  // commanded level of one rail
  typedef logic [2:0] level_t;
  localparam level_t LVL_ZERO = 3'h0;
  localparam level_t LVL_1V8  = 3'h1;
  localparam level_t LVL_3V3  = 3'h2;
  localparam level_t LVL_5V0  = 3'h3;
  localparam level_t LVL_HIZ  = 3'h4;
  typedef level_t [RAIL_COUNT-1:0] levels_t;

  // register byte offsets
  localparam logic [OFFSET_BITS-1:0] REG_CONTROL    = 8'h00;
  localparam logic [OFFSET_BITS-1:0] REG_STATUS     = 8'h04;
  localparam logic [OFFSET_BITS-1:0] REG_WORD       = 8'h08;
  localparam logic [OFFSET_BITS-1:0] REG_IRQ_STATUS = 8'h0C;
  localparam logic [OFFSET_BITS-1:0] REG_IRQ_MASK   = 8'h10;
  localparam int CTRL_SINGLE_SLOT = 0;

  // interrupt status bits
  localparam int IRQ_WORD_LOADED = 0;
  localparam int IRQ_OVERCURRENT = 1;
  localparam int IRQ_HOT_TRIP    = 2;
  localparam int IRQ_SLOT_COOL   = 3;

  typedef enum logic [1:0] {SLOT_RUN = 2'b01, SLOT_COOL = 2'b10} slot_e;

  // drive of one output rail
  typedef struct packed {
    level_t level;         // commanded level
    logic   lineOn;        // line switch closed
    logic   dischargeOn;   // discharge switch closed
    logic   currentLimit;  // linear limiting active
  } rail_s;

  typedef struct packed {
    logic                   hsel;
    logic [31:0]            haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [2:0]             hsize;
    logic [31:0]            hwdata;
    logic                   hready;
  } ahb_in_s;

  typedef struct packed {
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
  } ahb_out_s;

  // every pin input, sampled as one group
  typedef struct packed {
    logic                   linkClock;
    logic                   linkData;
    logic                   loadStrobe;
    logic                   resetPinN;
    logic                   shutdownPinN;
    logic                   shutdownResetPinN;
    logic [SELECT_BITS-1:0] parallelSelectBits;
    logic [RAIL_COUNT-1:0]  overcurrentFlags;
    logic                   thermalHigh;
    logic                   thermalLow;
    logic                   statusPinIn;
  } pins_s;

  // layout of the status register, bit 0 last
  typedef struct packed {
    logic                   statusPinIn;
    logic                   shutdownActive;
    logic                   resetActive;
    logic [SLOT_COUNT-1:0]  slotCooling;
    logic [RAIL_COUNT-1:0]  overcurrent;
    logic                   thermalLow;
    logic                   thermalHigh;
    logic                   faultReported;
    logic                   wordValid;
  } status_s;

endpackage

// file: rtl/card_power_switch_control.sv
// Function
// - shift serial bit on link clock rise
// - load strobe rise latches 11-bit word
// - reset drives all outputs to 0 V
// - dual stays discharged until new word
// - reset blocks word loading
// - status pin low on any fault
// - limit only the overcurrent output
// - high thermal trip opens every switch; discharge switches stay closed while reset is held
// - low trip disables faulty slot switches
// - re-enable on cooling, repeat while faulty
// - shutdown opens line and discharge switches; while reset is held the rails are discharged instead
// - discharge switch closed at 0 V
// - shutdown pin equals shutdown bit zero
// - reset acts without waiting for link
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
module card_power_switch_control (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire card_pwr_pkg::ahb_in_s         ahbIn,
  output card_pwr_pkg::ahb_out_s             ahbOut,
  input  wire logic                          linkClock,
  input  wire logic                          linkData,
  input  wire logic                          loadStrobe,
  input  wire logic                          resetPinN,
  input  wire logic                          shutdownPinN,
  input  wire logic                          shutdownResetPinN,
  input  wire logic [3:0]                    parallelSelectBits,
  input  wire logic [3:0]                    overcurrentFlags,
  input  wire logic                          thermalHigh,
  input  wire logic                          thermalLow,
  input  wire logic                          overcurrentStatusNIn,
  output logic                               overcurrentStatusNOut,
  output logic                               overcurrentStatusNOe,
  output card_pwr_pkg::rail_s [3:0]          railCtrl,
  output logic                               irq
);

  // whole state of the block
  typedef struct packed {
    card_pwr_pkg::pins_s                                     sync1;       // first sampling stage
    card_pwr_pkg::pins_s                                     sync2;       // second sampling stage
    logic                                                    prevClock;   // link clock, one cycle older
    logic                                                    prevStrobe;  // load strobe, one cycle older
    logic [card_pwr_pkg::WORD_BITS-1:0]                      shiftWord;   // serial shift register
    logic [card_pwr_pkg::WORD_BITS-1:0]                      activeWord;  // latched control word
    logic                                                    wordValid;   // word latched since reset
    card_pwr_pkg::slot_e [card_pwr_pkg::SLOT_COUNT-1:0]      slotState;   // low-trip cycle per slot
    logic                                                    singleSlot;  // parallel front end chosen
    logic [card_pwr_pkg::IRQ_BITS-1:0]                       irqStatus;   // sticky events
    logic [card_pwr_pkg::IRQ_BITS-1:0]                       irqMask;     // event enables
    logic [card_pwr_pkg::RAIL_COUNT-1:0]                     prevOver;    // for overcurrent edges
    logic                                                    prevHot;     // for high trip edge
    logic                                                    addrValid;   // bus data phase pending
    logic                                                    addrWrite;   // pending phase is a write
    logic [card_pwr_pkg::OFFSET_BITS-1:0]                    addrOffset;  // pending register offset
    card_pwr_pkg::rail_s [card_pwr_pkg::RAIL_COUNT-1:0]      rails;       // registered rail drive
    logic                                                    statusOe;    // pull status pin low
    logic                                                    statusOut;   // status pin level when driven
    logic                                                    irqOut;      // interrupt level
    logic [31:0]                                             hrdata;      // read data
    logic                                                    hreadyout;   // always ready after reset
    logic                                                    hresp;       // always okay
  } state_s;

  state_s                                s_q;           // registered state
  state_s                                s_d;           // next state
  card_pwr_pkg::pins_s                   pinsNow;       // raw pin group

  // group the pins so both stages are one assignment each
  assign pinsNow = '{linkClock: linkClock, linkData: linkData, loadStrobe: loadStrobe,
                     resetPinN: resetPinN, shutdownPinN: shutdownPinN,
                     shutdownResetPinN: shutdownResetPinN,
                     parallelSelectBits: parallelSelectBits,
                     overcurrentFlags: overcurrentFlags, thermalHigh: thermalHigh,
                     thermalLow: thermalLow, statusPinIn: overcurrentStatusNIn};

  // supply-side select: 00 zero, 01 3.3 V, 10 5 V, 11 zero
  function automatic card_pwr_pkg::level_t vccLevel(input logic hi, input logic lo);
    card_pwr_pkg::level_t lvl;
    unique case ({hi, lo})
      2'h1: lvl = card_pwr_pkg::LVL_3V3;
      2'h2: lvl = card_pwr_pkg::LVL_5V0;
      default: lvl = card_pwr_pkg::LVL_ZERO;
    endcase
    return lvl;
  endfunction

  // auxiliary select: sel0 sel1 pick zero, 3.3/5 V, open or 1.8 V
  function automatic card_pwr_pkg::level_t auxLevel(input logic sel0, input logic sel1, input logic hv);
    card_pwr_pkg::level_t lvl;
    unique case ({sel0, sel1})
      2'h0: lvl = card_pwr_pkg::LVL_ZERO;
      2'h1: lvl = hv ? card_pwr_pkg::LVL_5V0 : card_pwr_pkg::LVL_3V3;
      2'h2: lvl = card_pwr_pkg::LVL_HIZ;
      default: lvl = card_pwr_pkg::LVL_1V8;
    endcase
    return lvl;
  endfunction

  // dual-slot decode of the latched word
  function automatic card_pwr_pkg::levels_t dualLevels(input logic [card_pwr_pkg::WORD_BITS-1:0] w);
    card_pwr_pkg::levels_t lv;
    lv[card_pwr_pkg::RAIL_A_VCC] = vccLevel(w[card_pwr_pkg::BIT_A_VCC_HI], w[card_pwr_pkg::BIT_A_VCC_LO]);
    lv[card_pwr_pkg::RAIL_A_AUX] = auxLevel(w[card_pwr_pkg::BIT_A_AUX_SEL0], w[card_pwr_pkg::BIT_A_AUX_SEL1],
                                            w[card_pwr_pkg::BIT_A_AUX_HV]);
    lv[card_pwr_pkg::RAIL_B_VCC] = vccLevel(w[card_pwr_pkg::BIT_B_VCC_HI], w[card_pwr_pkg::BIT_B_VCC_LO]);
    lv[card_pwr_pkg::RAIL_B_AUX] = auxLevel(w[card_pwr_pkg::BIT_B_AUX_SEL0], w[card_pwr_pkg::BIT_B_AUX_SEL1],
                                            w[card_pwr_pkg::BIT_B_AUX_HV]);
    if (!w[card_pwr_pkg::SHUTDOWN_BIT]) begin
      lv = {card_pwr_pkg::RAIL_COUNT{card_pwr_pkg::LVL_HIZ}};
    end
    return lv;
  endfunction

  // single-slot decode of the four select bits, d[0] is the first select bit
  function automatic card_pwr_pkg::levels_t singleLevels(input logic [card_pwr_pkg::SELECT_BITS-1:0] d);
    card_pwr_pkg::levels_t lv;
    card_pwr_pkg::level_t  vcc;
    card_pwr_pkg::level_t  aux;
    vcc = card_pwr_pkg::LVL_HIZ;
    aux = card_pwr_pkg::LVL_HIZ;
    unique case ({d[0], d[1], d[2], d[3]})
      4'h0: begin
        vcc = card_pwr_pkg::LVL_ZERO;
        aux = card_pwr_pkg::LVL_ZERO;
      end
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB: begin
        // upper pair picks the supply, lower pair the auxiliary level
        vcc = d[0] ? card_pwr_pkg::LVL_5V0 : card_pwr_pkg::LVL_3V3;
        unique case ({d[2], d[3]})
          2'h0: aux = card_pwr_pkg::LVL_ZERO;
          2'h1: aux = card_pwr_pkg::LVL_3V3;
          2'h2: aux = card_pwr_pkg::LVL_5V0;
          default: aux = card_pwr_pkg::LVL_1V8;
        endcase
      end
      4'hD: vcc = card_pwr_pkg::LVL_3V3;
      4'hE: vcc = card_pwr_pkg::LVL_5V0;
      // remaining codes mean shutdown of both rails
      default: vcc = card_pwr_pkg::LVL_HIZ;
    endcase
    lv = {card_pwr_pkg::RAIL_COUNT{card_pwr_pkg::LVL_HIZ}};
    lv[card_pwr_pkg::RAIL_A_VCC] = vcc;
    lv[card_pwr_pkg::RAIL_A_AUX] = aux;
    return lv;
  endfunction

  // turn a commanded level into switch drives
  function automatic card_pwr_pkg::rail_s makeRail(input card_pwr_pkg::level_t lvl,
                                                   input logic disabled, input logic over);
    card_pwr_pkg::rail_s r;
    r.level        = lvl;
    r.lineOn       = !disabled && (lvl == card_pwr_pkg::LVL_1V8 || lvl == card_pwr_pkg::LVL_3V3 ||
                                   lvl == card_pwr_pkg::LVL_5V0);
    r.dischargeOn  = !disabled && (lvl == card_pwr_pkg::LVL_ZERO);
    r.currentLimit = over && r.lineOn;
    return r;
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic                                    clockRise;
    logic                                    strobeRise;
    logic                                    inReset;
    logic                                    inShutdown;
    logic                                    slotOver;
    logic                                    disabled;
    logic [card_pwr_pkg::IRQ_BITS-1:0]       events;
    logic [card_pwr_pkg::IRQ_BITS-1:0]       clearBits;
    logic [card_pwr_pkg::SLOT_COUNT-1:0]     cooling;
    card_pwr_pkg::levels_t                   cmd;
    card_pwr_pkg::status_s                   stat;
    logic                                    addrPhase;
    clockRise  = 1'b0;
    strobeRise = 1'b0;
    inReset    = 1'b0;
    inShutdown = 1'b0;
    slotOver   = 1'b0;
    disabled   = 1'b0;
    events     = '0;
    clearBits  = '0;
    cooling    = '0;
    cmd        = '0;
    stat       = '0;
    addrPhase  = 1'b0;
    s_d        = s_q;

    s_d.sync1      = pinsNow;
    s_d.sync2      = s_q.sync1;
    s_d.prevClock  = s_q.sync2.linkClock;
    s_d.prevStrobe = s_q.sync2.loadStrobe;
    clockRise      = s_q.sync2.linkClock & ~s_q.prevClock;
    strobeRise     = s_q.sync2.loadStrobe & ~s_q.prevStrobe;
    inReset        = ~s_q.sync2.resetPinN;
    inShutdown     = ~s_q.sync2.shutdownPinN | (s_q.singleSlot & ~s_q.sync2.shutdownResetPinN);

    if (clockRise) begin
      s_d.shiftWord = {s_q.shiftWord[card_pwr_pkg::WORD_BITS-2:0], s_q.sync2.linkData};
    end

    // reset blocks loading; a strobe rise loads the word held before this cycle's shift
    if (inReset) begin
      s_d.wordValid = 1'b0;
    end else if (strobeRise) begin
      s_d.activeWord = s_q.shiftWord;
      s_d.wordValid  = 1'b1;
      events[card_pwr_pkg::IRQ_WORD_LOADED] = 1'b1;
    end

    // commanded levels from the chosen front end
    if (s_q.singleSlot) begin
      cmd = singleLevels(s_q.sync2.parallelSelectBits);
    end else if (!s_q.wordValid) begin
      cmd = {card_pwr_pkg::RAIL_COUNT{card_pwr_pkg::LVL_ZERO}};
    end else begin
      cmd = dualLevels(s_q.activeWord);
    end
    if (inShutdown) begin
      cmd = {card_pwr_pkg::RAIL_COUNT{card_pwr_pkg::LVL_HIZ}};
    end
    // reset forces zero; it outranks shutdown so cards are always discharged
    if (inReset) begin
      cmd = {card_pwr_pkg::RAIL_COUNT{card_pwr_pkg::LVL_ZERO}};
    end

    // low thermal trip cycle, one machine per slot
    for (int i = 0; i < card_pwr_pkg::SLOT_COUNT; i++) begin
      slotOver = |s_q.sync2.overcurrentFlags[i*card_pwr_pkg::RAILS_PER_SLOT +: card_pwr_pkg::RAILS_PER_SLOT];
      unique case (s_q.slotState[i])
        card_pwr_pkg::SLOT_RUN: begin
          if (s_q.sync2.thermalLow && slotOver) begin
            s_d.slotState[i] = card_pwr_pkg::SLOT_COOL;
            events[card_pwr_pkg::IRQ_SLOT_COOL] = 1'b1;
          end
        end
        card_pwr_pkg::SLOT_COOL: begin
          if (!s_q.sync2.thermalLow) begin
            s_d.slotState[i] = card_pwr_pkg::SLOT_RUN;
          end
        end
        default: s_d.slotState[i] = card_pwr_pkg::SLOT_RUN;
      endcase
      cooling[i] = (s_q.slotState[i] == card_pwr_pkg::SLOT_COOL);
    end

    // rail drives; thermal disables never override reset discharge
    for (int r = 0; r < card_pwr_pkg::RAIL_COUNT; r++) begin
      disabled = !inReset && (s_q.sync2.thermalHigh || cooling[r / card_pwr_pkg::RAILS_PER_SLOT]);
      s_d.rails[r] = makeRail(cmd[r], disabled, s_q.sync2.overcurrentFlags[r]);
    end

    // status pin pulled low on fault
    s_d.statusOe  = (|s_q.sync2.overcurrentFlags) | s_q.sync2.thermalHigh | (|cooling);
    s_d.statusOut = 1'b0;

    // edge events for the interrupt logic
    s_d.prevOver = s_q.sync2.overcurrentFlags;
    s_d.prevHot  = s_q.sync2.thermalHigh;
    if (|(s_q.sync2.overcurrentFlags & ~s_q.prevOver)) begin
      events[card_pwr_pkg::IRQ_OVERCURRENT] = 1'b1;
    end
    if (s_q.sync2.thermalHigh && !s_q.prevHot) begin
      events[card_pwr_pkg::IRQ_HOT_TRIP] = 1'b1;
    end

    // bus data phase: writes land here, one cycle after the address phase
    if (s_q.addrValid && s_q.addrWrite) begin
      unique case (s_q.addrOffset)
        card_pwr_pkg::REG_CONTROL:    s_d.singleSlot = ahbIn.hwdata[card_pwr_pkg::CTRL_SINGLE_SLOT];
        card_pwr_pkg::REG_IRQ_STATUS: clearBits = ahbIn.hwdata[card_pwr_pkg::IRQ_BITS-1:0];
        card_pwr_pkg::REG_IRQ_MASK:   s_d.irqMask = ahbIn.hwdata[card_pwr_pkg::IRQ_BITS-1:0];
        // other offsets take the write and drop it
        default: s_d.irqMask = s_q.irqMask;
      endcase
    end

    // sticky status: a new event beats a clear in the same cycle
    s_d.irqStatus = (s_q.irqStatus & ~clearBits) | events;
    s_d.irqOut    = |(s_d.irqStatus & s_d.irqMask);

    // bus address phase; reads use next-state values so a write just before is seen
    addrPhase      = ahbIn.hsel && ahbIn.htrans[1] && ahbIn.hready;
    s_d.addrValid  = addrPhase;
    s_d.addrWrite  = ahbIn.hwrite;
    s_d.addrOffset = ahbIn.haddr[card_pwr_pkg::OFFSET_BITS-1:0];
    stat = '{statusPinIn: s_q.sync2.statusPinIn, shutdownActive: inShutdown, resetActive: inReset,
             slotCooling: cooling, overcurrent: s_q.sync2.overcurrentFlags,
             thermalLow: s_q.sync2.thermalLow, thermalHigh: s_q.sync2.thermalHigh,
             faultReported: s_d.statusOe, wordValid: s_d.wordValid};
    s_d.hrdata = '0;
    if (addrPhase && !ahbIn.hwrite) begin
      unique case (ahbIn.haddr[card_pwr_pkg::OFFSET_BITS-1:0])
        card_pwr_pkg::REG_CONTROL:    s_d.hrdata = 32'(s_d.singleSlot);
        card_pwr_pkg::REG_STATUS:     s_d.hrdata = 32'(stat);
        card_pwr_pkg::REG_WORD:       s_d.hrdata = 32'(s_d.activeWord);
        card_pwr_pkg::REG_IRQ_STATUS: s_d.hrdata = 32'(s_d.irqStatus);
        card_pwr_pkg::REG_IRQ_MASK:   s_d.hrdata = 32'(s_d.irqMask);
        // unmapped offsets read as zero
        default: s_d.hrdata = '0;
      endcase
    end
    s_d.hreadyout = 1'b1;
    s_d.hresp     = 1'b0;
  end

  // state register; the clear of everything is safe because rails then read as 0 V with line and discharge switches open
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q              <= '0;
      s_q.slotState[0] <= card_pwr_pkg::SLOT_RUN;
      s_q.slotState[1] <= card_pwr_pkg::SLOT_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign ahbOut                = '{hrdata: s_q.hrdata, hreadyout: s_q.hreadyout, hresp: s_q.hresp};
  assign overcurrentStatusNOut = s_q.statusOut;
  assign overcurrentStatusNOe  = s_q.statusOe;
  assign railCtrl              = s_q.rails;
  assign irq                   = s_q.irqOut;

endmodule

// file: test/card_power_switch_control_asserts.sv
`timescale 1ns/1ns
module card_power_switch_control_asserts (
  input wire logic                      clk_sys,
  input wire logic                      reset,
  input wire card_pwr_pkg::ahb_out_s    ahbOut,
  input wire logic                      resetPinN,
  input wire logic                      shutdownPinN,
  input wire logic [3:0]                overcurrentFlags,
  input wire logic                      thermalHigh,
  input wire logic                      thermalLow,
  input wire logic                      overcurrentStatusNOe,
  input wire card_pwr_pkg::rail_s [3:0] railCtrl
);
  logic [2:0] sinceRst_q;  // edges since release, saturating
  logic       up;          // pin synchronisers have flushed
  logic [3:0] lineOns;     // per rail line switch
  logic [3:0] disOns;      // per rail discharge switch
  logic [3:0] limits;      // per rail limiting
  logic [3:0] zeros;       // per rail commanded 0 V
  logic [3:0] hizs;        // per rail open
  // count up after reset so early samples of stale pins are skipped
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sinceRst_q <= 3'h0;
    end else if (!up) begin
      sinceRst_q <= sinceRst_q + 3'h1;
    end
  end
  assign up = (sinceRst_q == 3'h7);
  // flatten the rail structs
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      lineOns[r] = railCtrl[r].lineOn;
      disOns[r]  = railCtrl[r].dischargeOn;
      limits[r]  = railCtrl[r].currentLimit;
      zeros[r]   = (railCtrl[r].level == card_pwr_pkg::LVL_ZERO);
      hizs[r]    = (railCtrl[r].level == card_pwr_pkg::LVL_HIZ);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_slotA_hot;
    (up && thermalLow && !thermalHigh && resetPinN && shutdownPinN && overcurrentFlags == 4'h1) [*6];
  endsequence
  property p_reset_dis; (up && !resetPinN) [*5] |-> zeros == 4'hF && disOns == 4'hF && lineOns == 4'h0; endproperty
  a_reset_dis: assert property (p_reset_dis) else $error("card reset not discharging");
  property p_shut_hiz; (up && resetPinN && !shutdownPinN) [*5] |-> hizs == 4'hF && (lineOns | disOns) == 4'h0;
  endproperty
  a_shut_hiz: assert property (p_shut_hiz) else $error("shutdown pin not opening rails");
  property p_hot_open; (up && thermalHigh) [*5] |-> lineOns == 4'h0; endproperty
  a_hot_open: assert property (p_hot_open) else $error("hot trip left a switch on");
  property p_lim_line; (limits & ~lineOns) == 4'h0; endproperty
  a_lim_line: assert property (p_lim_line) else $error("limit on an open rail");
  property p_lim_flag; (up && overcurrentFlags == 4'h0) [*5] |-> limits == 4'h0; endproperty
  a_lim_flag: assert property (p_lim_flag) else $error("limit without overcurrent");
  property p_fault_pin; (up && overcurrentFlags != 4'h0) [*5] |-> overcurrentStatusNOe; endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("status pin not pulled low");
  property p_zero_dis; (up && resetPinN && !thermalHigh && !thermalLow) [*5] |-> (zeros & ~disOns) == 4'h0;
  endproperty
  a_zero_dis: assert property (p_zero_dis) else $error("zero rail without discharge");
  property p_slot_cool; s_slotA_hot |-> lineOns[1:0] == 2'h0; endproperty
  a_slot_cool: assert property (p_slot_cool) else $error("faulty slot not disabled");
  property p_bus_okay; up |-> ahbOut.hreadyout && !ahbOut.hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
endmodule
bind card_power_switch_control card_power_switch_control_asserts chk (.clk_sys, .reset, .ahbOut, .resetPinN,
  .shutdownPinN, .overcurrentFlags, .thermalHigh, .thermalLow, .overcurrentStatusNOe, .railCtrl);

// file: test/serial_ctrl_model.sv
`timescale 1ns/1ns
module serial_ctrl_model (
  output logic linkClock,
  output logic linkData,
  output logic loadStrobe
);
  // link clock stands low between frames
  initial begin
    linkClock  = 1'b0;
    linkData   = 1'b0;
    loadStrobe = 1'b0;
  end
  // oldest bit first, 160 ns per bit
  task automatic send_word(input logic [10:0] word);
    for (int i = 10; i >= 0; i--) begin
      linkData <= word[i];
      #40 linkClock <= 1'b1;
      #80 linkClock <= 1'b0;
      #40;
    end
    loadStrobe <= 1'b1;
    #160 loadStrobe <= 1'b0;
    linkData <= ~linkData;  // a released line must not look held
  endtask
endmodule

// file: test/card_power_switch_control_tb.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module card_power_switch_control_tb;
  logic                      clk_sys = 1'b0;
  logic                      reset = 1'b1;
  card_pwr_pkg::ahb_in_s     busReq = '0;  // master side, hready filled below
  card_pwr_pkg::ahb_in_s     ahbIn;
  card_pwr_pkg::ahb_out_s    ahbOut;
  logic                      linkClock, linkData, loadStrobe, irq;
  logic                      resetPinN = 1'b1, shutdownPinN = 1'b1, thermalHigh = 1'b0, thermalLow = 1'b0;
  logic [3:0]                overcurrentFlags = 4'h0;
  logic [3:0]                selBits = 4'h6;  // single-slot select, bit0 first: 3.3 V supply, 5 V aux
  logic                      overcurrentStatusNOut, overcurrentStatusNOe;
  card_pwr_pkg::rail_s [3:0] railCtrl;
  logic [31:0]               rd;
  int                        n_mismatch = 0, compares = 0;
  always #10 clk_sys = ~clk_sys;
  // single slave: its hreadyout is the bus hready
  always_comb begin
    ahbIn = busReq;
    ahbIn.hready = ahbOut.hreadyout;
  end
  serial_ctrl_model ctrl (.linkClock(linkClock), .linkData(linkData), .loadStrobe(loadStrobe));
  // parallel select held steady from the start; status pin read back through its pull-up
  card_power_switch_control dut (.clk_sys(clk_sys), .reset(reset), .ahbIn(ahbIn), .ahbOut(ahbOut),
    .linkClock(linkClock), .linkData(linkData), .loadStrobe(loadStrobe), .resetPinN(resetPinN),
    .shutdownPinN(shutdownPinN), .shutdownResetPinN(1'b1), .parallelSelectBits(selBits),
    .overcurrentFlags(overcurrentFlags), .thermalHigh(thermalHigh), .thermalLow(thermalLow),
    .overcurrentStatusNIn(!overcurrentStatusNOe), .overcurrentStatusNOut(overcurrentStatusNOut),
    .overcurrentStatusNOe(overcurrentStatusNOe), .railCtrl(railCtrl), .irq(irq));
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_ready();
    repeat (50) begin
      @(posedge clk_sys);
      if (ahbOut.hreadyout === 1'b1) return;
    end
    n_mismatch++;
    test_done();
  endtask
  // one single word transfer, entered just after an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    busReq.hsel <= 1'b1;
    busReq.haddr <= {24'h00_0000, a};
    busReq.htrans <= 2'h2;
    busReq.hwrite <= wr;
    busReq.hsize <= 3'h2;
    wait_ready();
    busReq.hsel <= 1'b0;
    busReq.htrans <= 2'h0;
    busReq.hwdata <= wd;
    wait_ready();
    rd = ahbOut.hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK("register", e, rd)
  endtask
  task automatic rail_chk(input int r, input card_pwr_pkg::level_t l, input logic on, input logic dis);
    `CHK("rail", {l, on, dis}, {railCtrl[r].level, railCtrl[r].lineOn, railCtrl[r].dischargeOn})
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);  // unmapped offset
    settle();
    rail_chk(0, card_pwr_pkg::LVL_ZERO, 1'b0, 1'b1);
    resetPinN <= 1'b0;
    ctrl.send_word(11'h164);
    settle();
    rail_chk(2, card_pwr_pkg::LVL_ZERO, 1'b0, 1'b1);
    resetPinN <= 1'b1;
    settle();
    rd_chk(8'h08, 32'h0000_0000);
    rail_chk(3, card_pwr_pkg::LVL_ZERO, 1'b0, 1'b1);
    bus(1'b1, 8'h10, 32'h0000_0003);
    ctrl.send_word(11'h164);
    settle();
    rd_chk(8'h08, 32'h0000_0164);
    rail_chk(0, card_pwr_pkg::LVL_3V3, 1'b1, 1'b0);
    rail_chk(1, card_pwr_pkg::LVL_ZERO, 1'b0, 1'b1);
    rail_chk(2, card_pwr_pkg::LVL_5V0, 1'b1, 1'b0);
    rail_chk(3, card_pwr_pkg::LVL_3V3, 1'b1, 1'b0);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, 8'h0C, 32'h0000_0001);
    settle();
    `CHK("irq", 1'b0, irq)
    overcurrentFlags <= 4'h1;
    settle();
    `CHK("limit", 2'h1, {railCtrl[2].currentLimit, railCtrl[0].currentLimit})
    `CHK("fault", 2'h2, {overcurrentStatusNOe, overcurrentStatusNOut})
    rd_chk(8'h0C, 32'h0000_0002);
    thermalLow <= 1'b1;
    settle();
    `CHK("cool", 2'h2, {railCtrl[2].lineOn, railCtrl[0].lineOn})
    thermalLow <= 1'b0;
    settle();
    rail_chk(0, card_pwr_pkg::LVL_3V3, 1'b1, 1'b0);
    thermalLow <= 1'b1;
    settle();
    `CHK("cool", 1'b0, railCtrl[0].lineOn)
    thermalLow <= 1'b0;
    overcurrentFlags <= 4'h0;
    thermalHigh <= 1'b1;
    settle();
    `CHK("hot", 2'h0, {railCtrl[2].lineOn, railCtrl[3].lineOn})
    thermalHigh <= 1'b0;
    shutdownPinN <= 1'b0;
    settle();
    rail_chk(1, card_pwr_pkg::LVL_HIZ, 1'b0, 1'b0);
    shutdownPinN <= 1'b1;
    ctrl.send_word(11'h064);
    settle();
    rail_chk(2, card_pwr_pkg::LVL_HIZ, 1'b0, 1'b0);
    bus(1'b1, 8'h00, 32'h0000_0001);
    settle();
    rail_chk(0, card_pwr_pkg::LVL_3V3, 1'b1, 1'b0);
    rail_chk(1, card_pwr_pkg::LVL_5V0, 1'b1, 1'b0);
    test_done();
  end
endmodule
